/* File: hdc_pkg.sv */
// package: constants and carriers of the halting debug control block
// Behaviour
// - control writes need the key in bits 31:16
// - reset sets sticky flag, read clears it
// - retirement outside debug sets sticky flag
// - lockup shows only to debugger, not halted
// - sleeping flag is read-only status
// - debug-state flag mirrors halted state
// - selector write clears ready, completion sets
// - snap-stall bit allows imprecise halt entry
// - mask bit masks interrupts when debug enabled
// - writing one to step enables stepping
// - halt bit halts, zero leaves, local clears
// - debug enable writable only by debugger
// - selector write starts transfer, halted only
// - direction zero reads core, one writes
// - codes 0-12 general, then link, resume
// - then status, main and process stack
// - without float unit, select is five bits
// - resume address bit zero reads as zero
// - data register is source and destination
`default_nettype none
package hdc_pkg;

   // ---------------------------------------------------------------
   // register indices on the access port
   // ---------------------------------------------------------------
   localparam logic [1:0]  HDC_IDX_HCS   = 2'h0;
   localparam logic [1:0]  HDC_IDX_SEL   = 2'h1;
   localparam logic [1:0]  HDC_IDX_DATA  = 2'h2;

   // ---------------------------------------------------------------
   // halt control/status fields
   // ---------------------------------------------------------------
   localparam logic [15:0] HDC_KEY       = 16'ha05f;
   localparam int          HDC_B_RSTSEEN = 25;
   localparam int          HDC_B_RETIRED = 24;
   localparam int          HDC_B_LOCKUP  = 19;
   localparam int          HDC_B_SLEEP   = 18;
   localparam int          HDC_B_HALTED  = 17;
   localparam int          HDC_B_READY   = 16;
   localparam int          HDC_B_SNAP    = 5;
   localparam int          HDC_B_MASK    = 3;
   localparam int          HDC_B_STEP    = 2;
   localparam int          HDC_B_HALT    = 1;
   localparam int          HDC_B_DBGEN   = 0;

   // ---------------------------------------------------------------
   // selector fields and select codes
   // ---------------------------------------------------------------
   localparam int          HDC_B_DIR     = 16;
   localparam logic [6:0]  HDC_SEL_LR    = 7'h0e;
   localparam logic [6:0]  HDC_SEL_RESUME = 7'h0f;
   localparam logic [6:0]  HDC_SEL_PSR   = 7'h10;
   localparam logic [6:0]  HDC_SEL_MSP   = 7'h11;
   localparam logic [6:0]  HDC_SEL_PSP   = 7'h12;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        src_dap;
      logic [1:0]  idx;
      logic [31:0] wdata;
   } hdc_acc_s;

   typedef struct packed {
      logic        debug_en;
      logic        halt;
      logic        step;
      logic        mask;
      logic        snap;
      logic        rst_seen;
      logic        retired;
      logic        ready;
      logic        busy;
      logic        xok;
      logic        xres;
      logic [31:0] data;
      logic [31:0] rdata;
      logic        rvalid;
      logic        xreq;
      logic        xwrite;
      logic [6:0]  xsel;
      logic [31:0] xwdata;
      logic        mask_act;
   } hdc_state_s;

   // reset-seen comes up set: a power-on reset is a reset
   localparam hdc_state_s HDC_STATE_RST =
      '{rst_seen: 1'b1, ready: 1'b1, default: '0};

endpackage : hdc_pkg
`default_nettype wire

/* File: hdc_sel_decode.sv */
// module: decoder of the core register select field
`default_nettype none
`timescale 1ns/1ps
module hdc_sel_decode
   import hdc_pkg::*;
#(
   parameter bit HAS_FP = 1'b0
) (
   // select field as written
   input  wire logic [6:0] sel,
   // decode result
   output var  logic       ok,
   output var  logic       resume
);

   logic [6:0] eff;

   // ---------------------------------------------------------------
   // codes 0..12 general, link, resume, status, main and process sp
   // ---------------------------------------------------------------
   always_comb begin
      // without a float unit only five bits select; upper must be 0
      eff = HAS_FP ? sel : {2'h0, sel[4:0]};
      ok = (eff <= HDC_SEL_PSP);
      if (!HAS_FP && sel[6:5] != 2'h0) begin
         ok = 1'b0;
      end
      resume = ok && (eff == HDC_SEL_RESUME);
   end

endmodule // hdc_sel_decode
`default_nettype wire

/* File: hdc_top.sv */
// module: halting debug control/status and core register transfer
`default_nettype none
`timescale 1ns/1ps
module hdc_top
   import hdc_pkg::*;
#(
   parameter bit HAS_FP = 1'b0
) (
   // clock and resets
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        local_rst,
   // register access port, debugger or software
   input  wire hdc_acc_s    acc,
   output var  logic [31:0] rd_data,
   output var  logic        rd_valid,
   // core status
   input  wire logic        core_halted,
   input  wire logic        core_lockup,
   input  wire logic        core_sleeping,
   input  wire logic        core_retire,
   // core control
   output var  logic        debug_en,
   output var  logic        halt_req,
   output var  logic        step_en,
   output var  logic        snap_stall,
   output var  logic        irq_mask,
   // core register transfer
   output var  logic        xfer_req,
   output var  logic        xfer_write,
   output var  logic [6:0]  xfer_sel,
   output var  logic [31:0] xfer_wdata,
   input  wire logic        xfer_done,
   input  wire logic [31:0] xfer_rdata
);

   // ---------------------------------------------------------------
   // state and decode
   // ---------------------------------------------------------------
   hdc_state_s  st;
   hdc_state_s  next_st;
   logic        hit_hcs;
   logic        wr_hcs;
   logic        rd_hcs;
   logic        wr_sel;
   logic        sel_ok;
   logic        sel_res;
   logic        done;
   logic [31:0] hcs_view;
   logic [31:0] got;

   // select decode of the word being written to the selector
   hdc_sel_decode #(
      .HAS_FP (HAS_FP)
   ) u_dec (
      .sel    (acc.wdata[6:0]),
      .ok     (sel_ok),
      .resume (sel_res)
   );

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   always_comb begin
      hit_hcs = acc.valid && (acc.idx == HDC_IDX_HCS);
      // a write without the key leaves every control bit alone
      wr_hcs  = hit_hcs && acc.write
                && (acc.wdata[31:16] == HDC_KEY);
      rd_hcs  = hit_hcs && !acc.write;
      // the selector only answers while the core is halted
      wr_sel  = acc.valid && acc.write && (acc.idx == HDC_IDX_SEL)
                && core_halted;
      // reserved selects complete at once with no core access
      done    = st.busy && (xfer_done || !st.xok);
   end

   // ---------------------------------------------------------------
   // status view of the halt control register
   // ---------------------------------------------------------------
   always_comb begin
      hcs_view = 32'h0000_0000;
      hcs_view[HDC_B_RSTSEEN] = st.rst_seen;
      hcs_view[HDC_B_RETIRED] = st.retired;
      // software never sees lockup; halting hides it
      hcs_view[HDC_B_LOCKUP]  = core_lockup && !core_halted
                                && acc.src_dap;
      hcs_view[HDC_B_SLEEP]   = core_sleeping;
      hcs_view[HDC_B_HALTED]  = core_halted;
      hcs_view[HDC_B_READY]   = st.ready;
      hcs_view[HDC_B_SNAP]    = st.snap;
      hcs_view[HDC_B_MASK]    = st.mask;
      hcs_view[HDC_B_STEP]    = st.step;
      hcs_view[HDC_B_HALT]    = st.halt;
      hcs_view[HDC_B_DBGEN]   = st.debug_en;
   end

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      got = xfer_rdata;

      // read answer, one cycle after the request
      next_st.rvalid = acc.valid && !acc.write;
      next_st.rdata  = 32'h0000_0000;
      if (acc.valid && !acc.write) begin
         case (acc.idx)
            HDC_IDX_HCS:  next_st.rdata = hcs_view;
            HDC_IDX_DATA: next_st.rdata = st.data;
            default:      next_st.rdata = 32'h0000_0000;
         endcase
      end

      // sticky flags: clear on read, a coinciding event wins
      if (rd_hcs) begin
         next_st.rst_seen = 1'b0;
         next_st.retired  = 1'b0;
      end
      if (core_retire && !core_halted) begin
         next_st.retired = 1'b1;
      end
      if (local_rst) begin
         next_st.rst_seen = 1'b1;
      end

      // keyed control write
      if (wr_hcs) begin
         if (acc.src_dap) begin
            next_st.debug_en = acc.wdata[HDC_B_DBGEN];
         end
         next_st.halt = acc.wdata[HDC_B_HALT];
         next_st.step = acc.wdata[HDC_B_STEP];
         next_st.mask = acc.wdata[HDC_B_MASK];
         next_st.snap = acc.wdata[HDC_B_SNAP];
      end
      // local reset drops the halt request only
      if (local_rst) begin
         next_st.halt = 1'b0;
      end
      // never reaches the non-maskable interrupt
      next_st.mask_act = next_st.debug_en && next_st.mask;

      // data register written through the port
      if (acc.valid && acc.write && acc.idx == HDC_IDX_DATA) begin
         next_st.data = acc.wdata;
      end

      // core register transfer
      next_st.xreq = 1'b0;
      if (wr_sel) begin
         next_st.ready  = 1'b0;
         next_st.busy   = 1'b1;
         next_st.xok    = sel_ok;
         next_st.xres   = sel_res;
         next_st.xsel   = acc.wdata[6:0];
         next_st.xwrite = acc.wdata[HDC_B_DIR];
         next_st.xreq   = sel_ok;
         next_st.xwdata = st.data;
         if (sel_res) begin
            next_st.xwdata[0] = 1'b0;
         end
      end else if (done) begin
         next_st.busy  = 1'b0;
         next_st.ready = 1'b1;
         // a read lands in the data register
         if (!st.xwrite && st.xok) begin
            if (st.xres) begin
               got[0] = 1'b0;
            end
            next_st.data = got;
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= HDC_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs, each straight from the state register
   // ---------------------------------------------------------------
   assign rd_data    = st.rdata;
   assign rd_valid   = st.rvalid;
   assign debug_en   = st.debug_en;
   assign halt_req   = st.halt;
   assign step_en    = st.step;
   assign snap_stall = st.snap;
   assign irq_mask   = st.mask_act;
   assign xfer_req   = st.xreq;
   assign xfer_write = st.xwrite;
   assign xfer_sel   = st.xsel;
   assign xfer_wdata = st.xwdata;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // transfer steps: a started selector write, then completion
   sequence s_start;
      wr_sel && sel_ok;
   endsequence

   sequence s_finish;
      st.busy && st.xok && xfer_done && !wr_sel;
   endsequence

   // keyless writes change none of halt, step, mask and debug enable
   chk_key_guard: assert property (
      hit_hcs && acc.write && acc.wdata[31:16] != HDC_KEY
      && !local_rst |=> $stable(st.halt) && $stable(st.step)
      && $stable(st.mask) && $stable(st.debug_en))
      else $error("control changed by keyless write");

   // a local reset is seen on a later status read
   chk_reset_seen: assert property (
      local_rst ##1 !rd_hcs ##1 rd_hcs |=> st.rdata[HDC_B_RSTSEEN])
      else $error("reset not reported");

   // read clears the reset flag when nothing coincides
   chk_reset_clear: assert property (
      rd_hcs && !local_rst |=> !st.rst_seen)
      else $error("reset flag not cleared by read");

   // retirement outside debug is never lost to a read
   chk_retire_set: assert property (
      core_retire && !core_halted |=> st.retired)
      else $error("retire flag lost");

   // halted core reports no lockup
   chk_lockup_view: assert property (
      rd_hcs && (core_halted || !acc.src_dap)
      |=> !st.rdata[HDC_B_LOCKUP])
      else $error("lockup shown when hidden");

   // debug-state flag mirrors the core
   chk_debug_view: assert property (
      rd_hcs |=> st.rdata[HDC_B_HALTED] == $past(core_halted))
      else $error("debug-state flag wrong");

   // started transfer drops ready and requests the core
   chk_ready_drop: assert property (
      s_start |=> !st.ready && st.busy && st.xreq
      ##1 (!st.xreq || $past(wr_sel)))
      else $error("transfer start wrong");

   // completion raises ready one cycle later
   chk_ready_done: assert property (
      s_finish |=> st.ready && !st.busy)
      else $error("ready not set on completion");

   // direction carried to the core
   chk_dir_bit: assert property (
      s_start |=> st.xwrite == $past(acc.wdata[HDC_B_DIR]))
      else $error("direction wrong");

   // selector ignored outside debug state
   chk_sel_ignore: assert property (
      acc.valid && acc.write && acc.idx == HDC_IDX_SEL
      && !core_halted && !st.busy |=> !st.xreq && !st.busy)
      else $error("transfer started while running");

   // keyed debugger write of enable and mask drives the mask out
   chk_mask_out: assert property (
      wr_hcs && acc.src_dap && acc.wdata[HDC_B_DBGEN]
      && acc.wdata[HDC_B_MASK] |=> irq_mask)
      else $error("interrupt mask not applied");

   // software cannot move debug enable
   chk_sw_dbgen: assert property (
      hit_hcs && acc.write && !acc.src_dap |=> $stable(st.debug_en))
      else $error("software changed debug enable");

   // local reset drops the halt request
   chk_halt_local: assert property (
      local_rst |=> !st.halt)
      else $error("halt kept over local reset");

   // keyed write of halt one raises the request
   chk_halt_set: assert property (
      wr_hcs && acc.wdata[HDC_B_HALT] && !local_rst |=> halt_req)
      else $error("halt request not raised");

   // resume address never carries bit zero
   chk_resume_b0: assert property (
      st.xreq && st.xres |-> !st.xwdata[0])
      else $error("resume bit zero sent");

   // read transfer result lands in the data register
   chk_read_data: assert property (
      s_finish and (!st.xwrite && !st.xres)
      |=> st.data == $past(xfer_rdata))
      else $error("read result not captured");

   // sleeping flag mirrors the core
   chk_sleep_view: assert property (
      rd_hcs |=> st.rdata[HDC_B_SLEEP] == $past(core_sleeping))
      else $error("sleeping flag wrong");

   // keyed write of step one enables stepping
   chk_step_set: assert property (
      wr_hcs && acc.wdata[HDC_B_STEP] |=> step_en)
      else $error("step not enabled");

   // keyed write of snap-stall one drives it out
   chk_snap_set: assert property (
      wr_hcs && acc.wdata[HDC_B_SNAP] |=> snap_stall)
      else $error("snap-stall not set");

   // reserved select: no core request, ready low for one cycle
   chk_reserved_sel: assert property (
      wr_sel && !sel_ok |=> !st.xreq && !st.ready)
      else $error("reserved select started a transfer");

   // a port write lands in the data register unless a read completes
   chk_data_write: assert property (
      acc.valid && acc.write && acc.idx == HDC_IDX_DATA && !done
      |=> st.data == $past(acc.wdata))
      else $error("data register write lost");

endmodule // hdc_top
`default_nettype wire

/* File: hdc_core_model.sv */
// core model: halts on request while debug is enabled and answers register transfers
`timescale 1ns/1ps
`default_nettype none
module hdc_core_model
   import hdc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // control from the block, answer latency from the testbench
   input  wire logic        debug_en,
   input  wire logic        halt_req,
   input  wire logic [3:0]  lat,
   // transfer request
   input  wire logic        xfer_req,
   input  wire logic        xfer_write,
   input  wire logic [6:0]  xfer_sel,
   input  wire logic [31:0] xfer_wdata,
   // answers
   output var  logic        core_halted,
   output var  logic        xfer_done,
   output var  logic [31:0] xfer_rdata,
   output var  logic [7:0]  xfer_count
);
   // ---------------------------------------------------------------
   // core register file and transfer engine
   // ---------------------------------------------------------------
   logic [31:0] regs [0:31];
   logic        busy;
   logic        wr;
   logic [4:0]  sel;
   logic [31:0] wd;
   logic [3:0]  cnt;

   // lat picks a prompt or slow answer; idle rdata toggles so stale data
   // never passes for an answer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         core_halted <= 1'b0;
         xfer_done   <= 1'b0;
         xfer_rdata  <= 32'h0;
         xfer_count  <= 8'h0;
         busy        <= 1'b0;
         wr          <= 1'b0;
         sel         <= 5'h0;
         wd          <= 32'h0;
         cnt         <= 4'h0;
         for (int i = 0; i < 32; i++) begin
            regs[i] <= 32'hc0de_0000 | 32'(i << 4);
         end
      end else begin
         core_halted <= halt_req & debug_en;
         xfer_done   <= 1'b0;
         xfer_rdata  <= ~xfer_rdata;
         if (xfer_req) begin
            busy       <= 1'b1;
            cnt        <= lat;
            wr         <= xfer_write;
            sel        <= xfer_sel[4:0];
            wd         <= xfer_wdata;
            xfer_count <= xfer_count + 8'h1;
         end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (busy) begin
            busy      <= 1'b0;
            xfer_done <= 1'b1;
            if (wr) begin
               regs[sel] <= wd;
            end else begin
               xfer_rdata <= regs[sel];
            end
         end
      end
   end
endmodule // hdc_core_model
`default_nettype wire

/* File: hdc_top_tb.sv */
// testbench: register access sequences against the debug control block
`timescale 1ns/1ps
`default_nettype none
module hdc_top_tb
   import hdc_pkg::*;
;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        local_rst = 1'b0;
   hdc_acc_s    acc = '0;
   logic [31:0] rd_data;
   logic        rd_valid;
   logic        core_halted;
   logic        core_lockup = 1'b0;
   logic        core_sleeping = 1'b0;
   logic        core_retire = 1'b0;
   logic        debug_en;
   logic        halt_req;
   logic        step_en;
   logic        snap_stall;
   logic        irq_mask;
   logic        xfer_req;
   logic        xfer_write;
   logic [6:0]  xfer_sel;
   logic [31:0] xfer_wdata;
   logic        xfer_done;
   logic [31:0] xfer_rdata;
   logic [7:0]  xfer_count;
   logic [3:0]  lat = 4'h0;
   int          failures = 0;
   int          num_checks = 0;
   localparam logic [6:0] RD_CODES [8] = '{7'h00, 7'h05, 7'h0c, HDC_SEL_LR,
      HDC_SEL_RESUME, HDC_SEL_PSR, HDC_SEL_MSP, HDC_SEL_PSP};

   always #20 clk_sys = ~clk_sys;

   hdc_top DUT (.clk_sys(clk_sys), .rst(rst), .local_rst(local_rst),
      .acc(acc), .rd_data(rd_data), .rd_valid(rd_valid),
      .core_halted(core_halted), .core_lockup(core_lockup),
      .core_sleeping(core_sleeping), .core_retire(core_retire),
      .debug_en(debug_en), .halt_req(halt_req), .step_en(step_en),
      .snap_stall(snap_stall), .irq_mask(irq_mask), .xfer_req(xfer_req),
      .xfer_write(xfer_write), .xfer_sel(xfer_sel),
      .xfer_wdata(xfer_wdata), .xfer_done(xfer_done),
      .xfer_rdata(xfer_rdata));

   hdc_core_model core (.clk_sys(clk_sys), .rst(rst), .debug_en(debug_en),
      .halt_req(halt_req), .lat(lat), .xfer_req(xfer_req),
      .xfer_write(xfer_write), .xfer_sel(xfer_sel),
      .xfer_wdata(xfer_wdata), .core_halted(core_halted),
      .xfer_done(xfer_done), .xfer_rdata(xfer_rdata),
      .xfer_count(xfer_count));

   // ---------------------------------------------------------------
   // compare and access tasks
   // ---------------------------------------------------------------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask

   // request held over one edge; answer is taken just after that same edge
   task automatic xact(input logic w, input logic src, input logic [1:0] idx,
                       input logic [31:0] d, input logic rt,
                       output logic [31:0] q);
      @(posedge clk_sys);
      #1;
      acc = '{valid: 1'b1, write: w, src_dap: src, idx: idx, wdata: d};
      core_retire = rt;
      @(posedge clk_sys);
      #1;
      acc.valid = 1'b0;
      core_retire = 1'b0;
      q = rd_data;
      if (!w) chk_bit(rd_valid, 1'b1, "read answer");
   endtask

   task automatic wr(input logic src, input logic [1:0] idx,
                     input logic [31:0] d);
      logic [31:0] q;
      xact(1'b1, src, idx, d, 1'b0, q);
   endtask

   task automatic rd(input logic src, input logic [1:0] idx,
                     output logic [31:0] q);
      xact(1'b0, src, idx, 32'h0, 1'b0, q);
   endtask

   // bounded poll of the ready flag
   task automatic wait_ready();
      logic [31:0] q;
      int          n;
      q = 32'h0;
      n = 0;
      while (q[HDC_B_READY] !== 1'b1 && n < 20) begin
         rd(1'b1, HDC_IDX_HCS, q);
         n++;
      end
      chk_bit(q[HDC_B_READY], 1'b1, "ready after transfer");
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin : main
      logic [31:0] q;
      logic [7:0]  n0;
      logic [6:0]  c;
      repeat (10) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      rd(1'b1, HDC_IDX_HCS, q);
      chk_reg(q, 32'h0201_0000, "status after reset");
      rd(1'b1, HDC_IDX_HCS, q);
      chk_reg(q, 32'h0001_0000, "status cleared by read");
      core_lockup = 1'b1;
      core_sleeping = 1'b1;
      rd(1'b1, HDC_IDX_HCS, q);
      chk_reg(q, 32'h000d_0000, "debugger view");
      rd(1'b0, HDC_IDX_HCS, q);
      chk_reg(q, 32'h0005_0000, "software view");
      core_sleeping = 1'b0;
      // a retirement at the clearing read must survive it
      xact(1'b0, 1'b1, HDC_IDX_HCS, 32'h0, 1'b1, q);
      rd(1'b1, HDC_IDX_HCS, q);
      chk_bit(q[HDC_B_RETIRED], 1'b1, "retired kept");
      rd(1'b1, HDC_IDX_HCS, q);
      chk_bit(q[HDC_B_RETIRED], 1'b0, "retired cleared");
      wr(1'b1, HDC_IDX_HCS, 32'h0000_0003);
      chk_bit(debug_en, 1'b0, "keyless write");
      chk_bit(halt_req, 1'b0, "keyless halt");
      wr(1'b0, HDC_IDX_HCS, {HDC_KEY, 16'h0003});
      chk_bit(debug_en, 1'b0, "software enable");
      chk_bit(halt_req, 1'b1, "software halt bit");
      wr(1'b1, HDC_IDX_HCS, {HDC_KEY, 16'h0003});
      chk_bit(debug_en, 1'b1, "debugger enable");
      rd(1'b1, HDC_IDX_HCS, q);
      chk_reg(q, 32'h0003_0003, "halted view");
      core_lockup = 1'b0;
      wr(1'b1, HDC_IDX_HCS, {HDC_KEY, 16'h000b});
      chk_bit(irq_mask, 1'b1, "mask set");
      wr(1'b1, HDC_IDX_HCS, {HDC_KEY, 16'h0007});
      chk_bit(step_en, 1'b1, "step set");
      chk_bit(irq_mask, 1'b0, "mask cleared");
      // codes 0, 5, 12, link, resume, status, main and process sp read, prompt and slow answers alternating
      for (int i = 0; i < 8; i++) begin
         lat = i[0] ? 4'h6 : 4'h0;
         wr(1'b1, HDC_IDX_SEL, {25'h0, RD_CODES[i]});
         chk_reg({25'h0, xfer_sel}, {25'h0, RD_CODES[i]}, "select");
         chk_bit(xfer_write, 1'b0, "read direction");
         if (i[0]) begin
            rd(1'b1, HDC_IDX_HCS, q);
            chk_bit(q[HDC_B_READY], 1'b0, "ready low");
         end
         wait_ready();
         rd(1'b1, HDC_IDX_DATA, q);
         chk_reg(q, 32'hc0de_0000 | {21'h0, RD_CODES[i], 4'h0}, "read");
      end
      for (int i = 0; i < 2; i++) begin
         c = i[0] ? HDC_SEL_RESUME : 7'h05;
         wr(1'b1, HDC_IDX_DATA, 32'h5a5a_1235);
         wr(1'b1, HDC_IDX_SEL, {15'h0, 1'b1, 9'h0, c});
         chk_bit(xfer_write, 1'b1, "write direction");
         chk_reg(xfer_wdata, i[0] ? 32'h5a5a_1234 : 32'h5a5a_1235,
                 "write data out");
         wait_ready();
         wr(1'b1, HDC_IDX_SEL, {25'h0, c});
         wait_ready();
         rd(1'b1, HDC_IDX_DATA, q);
         chk_reg(q, i[0] ? 32'h5a5a_1234 : 32'h5a5a_1235, "written");
      end
      for (int i = 0; i < 2; i++) begin
         n0 = xfer_count;
         wr(1'b1, HDC_IDX_SEL, i[0] ? 32'h0000_0025 : 32'h0000_0013);
         repeat (3) @(posedge clk_sys);
         #1;
         chk_reg({24'h0, xfer_count}, {24'h0, n0}, "reserved code");
         rd(1'b1, HDC_IDX_HCS, q);
         chk_bit(q[HDC_B_READY], 1'b1, "ready after reserved");
      end
      wr(1'b1, 2'h3, 32'hffff_ffff);
      rd(1'b1, 2'h3, q);
      chk_reg(q, 32'h0, "unmapped read");
      rd(1'b1, HDC_IDX_SEL, q);
      chk_reg(q, 32'h0, "selector read");
      wr(1'b1, HDC_IDX_HCS, {HDC_KEY, 16'h0001});
      chk_bit(halt_req, 1'b0, "halt released");
      repeat (2) @(posedge clk_sys);
      #1;
      n0 = xfer_count;
      wr(1'b1, HDC_IDX_SEL, 32'h0000_0000);
      repeat (3) @(posedge clk_sys);
      #1;
      chk_reg({24'h0, xfer_count}, {24'h0, n0}, "select while running");
      // snap-stall only while running, and a reset follows before resuming
      wr(1'b1, HDC_IDX_HCS, {HDC_KEY, 16'h0023});
      chk_bit(snap_stall, 1'b1, "snap-stall set");
      local_rst = 1'b1;
      @(posedge clk_sys);
      #1;
      local_rst = 1'b0;
      chk_bit(halt_req, 1'b0, "local reset halt");
      rd(1'b1, HDC_IDX_HCS, q);
      chk_bit(q[HDC_B_RSTSEEN], 1'b1, "reset seen");
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      chk_bit(snap_stall, 1'b0, "snap-stall after reset");
      chk_bit(debug_en, 1'b0, "enable after reset");
      end_of_test();
   end

   // watchdog: the sequence needs well under a thousand cycles
   initial begin : watchdog
      repeat (3000) @(posedge clk_sys);
      failures++;
      end_of_test();
   end
endmodule // hdc_top_tb
`default_nettype wire
